/* File: verilog/sram_host_pkg.sv */
// constants for the host-side controller of a 1024 x 4 asynchronous static memory
// assumes one 100 MHz clock and the memory's pins wired straight to the controller
`default_nettype none
package sram_host_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 4;
	localparam int DEPTH = 1024;
	localparam int CLK_PERIOD_NS = 10;
	// slowest grade figures, in ns
	localparam int ACCESS_NS = 55;
	localparam int ACCESS_SHORT_IDLE_NS = 65;
	localparam int LONG_IDLE_NS = 55;
	localparam int WRITE_PULSE_NS = 40;
	localparam int DATA_SETUP_NS = 20;
	localparam int ADDR_HOLD_NS = 5;
	localparam int BUS_RELEASE_NS = 20;
	// least times round up, none below one cycle
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ACCESS_LONG_CYC = CNT_W'(cyc_up(ACCESS_NS) + 1);
	localparam logic [CNT_W-1:0] ACCESS_SHORT_CYC = CNT_W'(cyc_up(ACCESS_SHORT_IDLE_NS) + 1);
	localparam logic [CNT_W-1:0] WRITE_PULSE_CYC = CNT_W'(cyc_up(WRITE_PULSE_NS));
	localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(cyc_up(ADDR_HOLD_NS));
	localparam logic [CNT_W-1:0] RELEASE_CYC = CNT_W'(cyc_up(BUS_RELEASE_NS));
	localparam logic [CNT_W-1:0] LONG_IDLE_CYC = CNT_W'(cyc_up(LONG_IDLE_NS) + 1);
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b011,
		ST_HOLD = 3'b010,
		ST_RELEASE = 3'b110
	} host_state_t;
endpackage
`default_nettype wire

/* File: verilog/sram_idle_timer.sv */
// counts cycles the memory has been deselected, saturating
// assumes deselected is the registered chip select level of the host
`default_nettype none
module sram_idle_timer
	import sram_host_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic deselected,
	output logic long_idle
);
	logic [CNT_W-1:0] idle_cnt_r;
	// a reset may cut a selected access, so the idle time before it is unknown: assume short
	always_ff @(posedge clock)
	begin
		if (srst)
			idle_cnt_r <= CNT_ZERO;
		else if (!deselected)
			idle_cnt_r <= CNT_ZERO;
		else if (idle_cnt_r != LONG_IDLE_CYC)
			idle_cnt_r <= idle_cnt_r + CNT_ONE;
	end
	// strictly more than the idle threshold counts as long
	assign long_idle = (idle_cnt_r == LONG_IDLE_CYC);
endmodule
`default_nettype wire

/* File: verilog/async_sram_1k_by_4_host.sv */
// host controller driving a 1024 x 4 asynchronous static memory over its pins
// assumes memory pins are sampled synchronously to clock; pad logic joins data out/in/oe
`default_nettype none
module async_sram_1k_by_4_host
	import sram_host_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
	input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
	output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
	output logic chip_select_n,
	output logic write_enable_n,
	output logic [sram_host_pkg::DATA_W-1:0] data_pin_out,
	output logic data_pin_oe,
	input wire logic [sram_host_pkg::DATA_W-1:0] data_pin_in
);
	import sram_host_pkg::*;

	host_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic write_r;
	logic long_idle;

	sram_idle_timer u_idle (
		.clock(clock),
		.srst(srst),
		.deselected(chip_select_n),
		.long_idle(long_idle)
	);

	wire logic cnt_done = (cnt_r == CNT_ONE);
	wire logic take = req_ready && req_valid;

	// sequencing
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r <= ST_IDLE;
			cnt_r <= CNT_ZERO;
			write_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (take)
					begin
						write_r <= req_write;
						state_r <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					state_r <= ST_STROBE;
					// reads wait longer when reselected soon after a deselect; writes always use the write pulse
					if (write_r)
						cnt_r <= WRITE_PULSE_CYC;
					else if (long_idle)
						cnt_r <= ACCESS_LONG_CYC;
					else
						cnt_r <= ACCESS_SHORT_CYC;
				end
				ST_STROBE:
				begin
					if (cnt_done)
					begin
						state_r <= ST_HOLD;
						cnt_r <= HOLD_CYC;
					end
					else
						cnt_r <= cnt_r - CNT_ONE;
				end
				ST_HOLD:
				begin
					if (cnt_done)
					begin
						state_r <= ST_RELEASE;
						cnt_r <= RELEASE_CYC;
					end
					else
						cnt_r <= cnt_r - CNT_ONE;
				end
				ST_RELEASE:
				begin
					// the memory may still drive the pins for a while after a read
					if (cnt_done)
						state_r <= ST_IDLE;
					else
						cnt_r <= cnt_r - CNT_ONE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// request port handshake
	always_ff @(posedge clock)
	begin
		if (srst)
			req_ready <= 1'b0;
		else if (take)
			req_ready <= 1'b0;
		else
			req_ready <= (state_r == ST_IDLE) || (state_r == ST_RELEASE && cnt_done);
	end

	// address and write data stand from setup through hold
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mem_addr <= '0;
			data_pin_out <= '0;
		end
		else if (take)
		begin
			mem_addr <= req_addr;
			data_pin_out <= req_wdata;
		end
	end

	// select low for the strobe; raised first so write enable never ends a write alone
	always_ff @(posedge clock)
	begin
		if (srst)
			chip_select_n <= 1'b1;
		else if (state_r == ST_SETUP)
			chip_select_n <= 1'b0;
		else if (state_r == ST_STROBE && cnt_done)
			chip_select_n <= 1'b1;
	end

	// write enable falls with select and rises one cycle after it
	always_ff @(posedge clock)
	begin
		if (srst)
			write_enable_n <= 1'b1;
		else if (state_r == ST_SETUP && write_r)
			write_enable_n <= 1'b0;
		else if (state_r == ST_HOLD)
			write_enable_n <= 1'b1;
	end

	// host drives pins only for writes, data held past select rise
	always_ff @(posedge clock)
	begin
		if (srst)
			data_pin_oe <= 1'b0;
		else if (take)
			data_pin_oe <= req_write;
		else if (state_r == ST_HOLD && cnt_done)
			data_pin_oe <= 1'b0;
	end

	// sample read data at the last strobe cycle
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end
		else
		begin
			rsp_valid <= (state_r == ST_STROBE) && cnt_done && !write_r;
			if ((state_r == ST_STROBE) && cnt_done && !write_r)
				rsp_rdata <= data_pin_in;
		end
	end

	sequence s_write_start;
		!chip_select_n && !write_enable_n;
	endsequence
	sequence s_write_end;
		chip_select_n ##1 write_enable_n;
	endsequence

	property p_no_clash;
		@(posedge clock) disable iff (srst)
		!(data_pin_oe && !chip_select_n && write_enable_n);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("host drives pins during read");

	property p_write_hold;
		@(posedge clock) disable iff (srst)
		s_write_start |-> data_pin_oe;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write data not driven");

	property p_write_pulse;
		@(posedge clock) disable iff (srst)
		$fell(write_enable_n) |-> (!write_enable_n && !chip_select_n)[*4];
	endproperty
	a_write_pulse: assert property (p_write_pulse) else $error("write pulse too short");

	property p_select_ends;
		@(posedge clock) disable iff (srst)
		$rose(chip_select_n) && !write_enable_n |-> data_pin_oe ##1 write_enable_n;
	endproperty
	a_select_ends: assert property (p_select_ends) else $error("write end not select led");

	property p_write_order;
		@(posedge clock) disable iff (srst)
		$fell(write_enable_n) |-> ##[1:8] s_write_end;
	endproperty
	a_write_order: assert property (p_write_order) else $error("write not ended in time");

	property p_read_resp;
		@(posedge clock) disable iff (srst)
		$fell(chip_select_n) && write_enable_n |-> ##[6:8] rsp_valid;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("read answer out of window");

	property p_short_idle;
		@(posedge clock) disable iff (srst)
		$fell(chip_select_n) && write_enable_n && !$past(long_idle) |-> !rsp_valid[*8];
	endproperty
	a_short_idle: assert property (p_short_idle) else $error("short idle access too fast");

	property p_addr_stable;
		@(posedge clock) disable iff (srst)
		!chip_select_n |-> $stable(mem_addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");
endmodule
`default_nettype wire

/* File: tb/sram_far_model.sv */
// behavioural 1024 x 4 static memory on the far side of the host
// assumes the host pins arrive unchanged
`default_nettype none
module sram_far_model
	import sram_host_pkg::*;
#(
	parameter bit POWER_DOWN = 1'b1
)
(
	input wire logic [sram_host_pkg::ADDR_W-1:0] addr,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic [sram_host_pkg::DATA_W-1:0] din,
	output logic [sram_host_pkg::DATA_W-1:0] dout,
	output logic drive,
	output logic asleep
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] mem [DEPTH];
	logic ok = 1'b0;
	realtime left_at = 0;
	wire wr_on = !cs_n && !we_n;
	// stored when the overlap ends, so either strobe may end it
	always @(negedge wr_on)
		mem[addr] = din;
	assign drive = !cs_n && we_n;
	assign asleep = POWER_DOWN && cs_n;
	// wrong data until the access time has run out
	always @(negedge cs_n)
	begin
		ok = 1'b0;
		#(($realtime - left_at > 55) ? 35 : 45) ok = 1'b1;
	end
	always @(posedge cs_n)
	begin
		left_at = $realtime;
		ok = 1'b0;
	end
	assign dout = ok ? mem[addr] : ~mem[addr];
endmodule
`default_nettype wire

/* File: tb/tb_async_sram_1k_by_4_host.sv */
// self-checking bench: host controller against the behavioural memory
// assumes one 100 MHz clock; the shared data pins are resolved here
`default_nettype none
module tb_async_sram_1k_by_4_host;
	timeunit 1ns;
	timeprecision 1ns;
	import sram_host_pkg::*;
	typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} row_t;
	localparam row_t ROWS [10] = '{
		'{1'b1, 10'h000, 4'h5}, '{1'b1, 10'h3ff, 4'ha}, '{1'b1, 10'h155, 4'h3}, '{1'b1, 10'h2aa, 4'h0},
		'{1'b0, 10'h000, 4'h5}, '{1'b0, 10'h3ff, 4'ha}, '{1'b1, 10'h000, 4'hf}, '{1'b0, 10'h000, 4'hf},
		'{1'b0, 10'h155, 4'h3}, '{1'b0, 10'h2aa, 4'h0}};
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic req_ready, rsp_valid, chip_select_n, write_enable_n, data_pin_oe, mem_drive;
	logic [DATA_W-1:0] rsp_rdata, data_pin_out, mem_q, data_pin_in, got;
	logic [DATA_W-1:0] last_dq = '0;
	logic [ADDR_W-1:0] mem_addr;
	int n_mismatch = 0;
	int n_compared = 0;
	int lat;
	always #5 clock = ~clock;
	// a released bus toggles, so a stale sample cannot pass
	assign data_pin_in = data_pin_oe ? data_pin_out : mem_drive ? mem_q : ~last_dq;
	always @(posedge clock)
		last_dq <= data_pin_in;
	async_sram_1k_by_4_host async_sram_1k_by_4_host_inst (.clock(clock), .srst(srst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
		.chip_select_n(chip_select_n), .write_enable_n(write_enable_n), .data_pin_out(data_pin_out),
		.data_pin_oe(data_pin_oe), .data_pin_in(data_pin_in));
	sram_far_model sram_far_model_inst (.addr(mem_addr), .cs_n(chip_select_n), .we_n(write_enable_n),
		.din(data_pin_in), .dout(mem_q), .drive(mem_drive), .asleep());
	task automatic close_out();
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(inout int n);
		@(negedge clock);
		n++;
		if (n > 60)
		begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic do_req(input row_t r, output int lat, output logic [DATA_W-1:0] q);
		int n;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= r.w;
		req_addr <= r.a;
		req_wdata <= r.d;
		n = 0;
		lat = 0;
		q = '0;
		step(n);
		while (req_ready !== 1'b1)
			step(n);
		@(posedge clock);
		req_valid <= 1'b0;
		while (!r.w && rsp_valid !== 1'b1)
			step(lat);
		q = rsp_rdata;
	endtask
	always @(negedge clock)
	begin
		if (data_pin_oe === 1'b1 && mem_drive === 1'b1)
			chk("bus contention", 0, 1);
		if (write_enable_n === 1'b0 && data_pin_oe !== 1'b1)
			chk("write data held", 1, 0);
	end
	initial
	begin
		repeat (3) @(posedge clock);
		chk("pins in reset", 5'h18, {chip_select_n, write_enable_n, data_pin_oe, req_ready, rsp_valid});
		srst <= 1'b0;
		foreach (ROWS[i])
		begin
			do_req(ROWS[i], lat, got);
			if (!ROWS[i].w)
			begin
				chk("read data", ROWS[i].d, got);
				chk("read latency", 1, lat inside {9, 10});
			end
		end
		repeat (20) @(posedge clock);
		do_req(row_t'{1'b0, 10'h3ff, 4'ha}, lat, got);
		chk("long idle latency", 9, lat);
		do_req(row_t'{1'b0, 10'h155, 4'h3}, lat, got);
		chk("short idle latency", 10, lat);
		chk("short idle data", 4'h3, got);
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= 1'b1;
		req_wdata <= 4'hc;
		lat = 0;
		while (write_enable_n !== 1'b0)
			step(lat);
		@(posedge clock);
		srst <= 1'b1;
		req_valid <= 1'b0;
		repeat (2) @(negedge clock);
		chk("pins after abort", 3'h6, {chip_select_n, write_enable_n, data_pin_oe});
		@(posedge clock);
		srst <= 1'b0;
		do_req(row_t'{1'b0, 10'h2aa, 4'h0}, lat, got);
		chk("data after abort", 4'h0, got);
		chk("reset idle latency", 10, lat);
		close_out();
	end
endmodule
`default_nettype wire
